// ==== sbc_pkg.sv ====
// Contract
// - all command, address and data inputs are sampled on the rising clock edge
// - x16 organisation: four banks of 8,192 rows by 1K columns of 16 bits
// - x32 organisation: 8,192 rows by 512 columns of 32 bits per bank
// - reduced page x32: 16,384 rows by 256 columns, one more row bit
// - activate takes bank select inputs as bank and address as row
// - read or write takes address as starting column in the open row
// - burst length 1, 2, 4 or 8; burst terminate ends a burst early
// - burst runs alone, columns generated internally in programmed order
// - auto precharge closes the row by itself when the burst ends
// - a new column address is accepted on every clock cycle
// - one bank may be precharged while another is being accessed
// - auto refresh and deep sleep mode are entered by command
// - chip select high masks every command
// - precharge with address bit high closes all banks, else the selected one
// - mask high drops write lanes and floats read lanes two clocks later
// - clock enable low freezes the clock: suspend, power down, self refresh
package sbc_pkg;

  // ****************************************
  // array geometry
  // ****************************************
  localparam int BANKS      = 4;
  localparam int ADDR_W     = 14;
  localparam int ROW_W      = 14;
  localparam int COL_W      = 10;
  localparam int DQ_W       = 32;
  localparam int LANES      = 4;
  localparam int LIN_W      = 25;
  localparam int MEM_AW_DEF = 12;
  localparam int AP_BIT     = 10;

  // organisation select values
  localparam logic [1:0] ORG_X16  = 2'h0;
  localparam logic [1:0] ORG_X32  = 2'h1;
  localparam logic [1:0] ORG_X32R = 2'h2;
  localparam logic [1:0] ORG_RST  = 2'h0;
  localparam logic [3:0] LANES_X16 = 4'h3;
  localparam logic [3:0] LANES_X32 = 4'hF;

  // ****************************************
  // command codes {cs_n, ras_n, cas_n, we_n}
  // ****************************************
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;

  // ****************************************
  // mode word fields
  // ****************************************
  localparam int         MR_W      = 7;
  localparam int         MR_BL_LSB = 0;
  localparam int         MR_BT_BIT = 3;
  localparam int         MR_CL_LSB = 4;
  localparam logic [6:0] MR_RST    = 7'h23;
  localparam logic [2:0] CL_THREE  = 3'h3;

  // ****************************************
  // register offsets
  // ****************************************
  localparam int         PADDR_W  = 8;
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_RCNT = 8'h0C;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sbc_cmd_t;

  typedef struct packed {
    logic             wr;
    logic             ap;
    logic [1:0]       bank;
    logic [COL_W-1:0] col;
    logic [2:0]       idx;
    logic [3:0]       cnt;
  } sbc_burst_t;

  typedef enum logic [3:0] {
    PW_RUN  = 4'b0001,
    PW_DOWN = 4'b0010,
    PW_SELF = 4'b0100,
    PW_DEEP = 4'b1000
  } sbc_pwr_t;

endpackage

// ==== sbc_mem.sv ====
`timescale 1ns/100ps
module sbc_mem
  import sbc_pkg::*;
#(
  parameter int AW = MEM_AW_DEF,
  parameter int DW = DQ_W
) (
  input  wire logic            core_clk, // clock
  input  wire logic [AW-1:0]   addr,     // word address
  input  wire logic            we,       // write strobe
  input  wire logic            re,       // read strobe
  input  wire logic [DW/8-1:0] be,       // byte enables
  input  wire logic [DW-1:0]   wdata,    // write data
  output logic      [DW-1:0]   rdata     // registered read data
);

  // ****************************************
  // storage
  // ****************************************
  logic [DW-1:0] mem [2**AW];

  // byte-wise write, read data held until next read
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DW/8; i++) begin
      if (we && be[i]) begin
        mem[addr][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule

// ==== sbc_core.sv ====
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
module sbc_core
  import sbc_pkg::*;
#(
  parameter int MEM_AW = MEM_AW_DEF
) (
  input  wire logic               core_clk,        // system clock
  input  wire logic               rst_n,           // async reset
  input  wire logic               psel,            // apb select
  input  wire logic               penable,         // apb enable
  input  wire logic               pwrite,          // apb direction
  input  wire logic [PADDR_W-1:0] paddr,           // apb byte address
  input  wire logic [31:0]        pwdata,          // apb write data
  output logic      [31:0]        prdata,          // apb read data
  output logic                    pready,          // apb ready
  output logic                    pslverr,         // apb error
  input  wire logic               cke,             // clock enable
  input  wire logic               cs_n,            // chip select
  input  wire logic               ras_n,           // row strobe
  input  wire logic               cas_n,           // column strobe
  input  wire logic               we_n,            // write strobe
  input  wire logic               bank_sel_bit0,   // bank select lsb
  input  wire logic               bank_sel_bit1,   // bank select msb
  input  wire logic [ADDR_W-1:0]  addr,            // row/column address
  input  wire logic               low_byte_mask,   // lane 0 mask
  input  wire logic               high_byte_mask,  // lane 1 mask
  input  wire logic [1:0]         upper_lane_mask, // lanes 3:2 mask
  input  wire logic [DQ_W-1:0]    dq_in,           // data from bus
  output logic      [DQ_W-1:0]    dq_out,          // data to bus
  output logic      [LANES-1:0]   dq_oe            // lane drive enables
);

  // ****************************************
  // helpers
  // ****************************************
  // column of a beat inside the wrap window
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [2:0] idx,
                                                 input logic [1:0] blc,
                                                 input logic bt);
    logic [2:0] msk;
    logic [2:0] low;
    msk = 3'((4'h1 << blc) - 4'h1);
    low = bt ? (start[2:0] ^ idx) : 3'(start[2:0] + idx);
    return {start[COL_W-1:3], (start[2:0] & ~msk) | (low & msk)};
  endfunction

  // linear word index per organisation
  function automatic logic [LIN_W-1:0] lin_addr(input logic [1:0] org,
                                                input logic [1:0] bank,
                                                input logic [ROW_W-1:0] row,
                                                input logic [COL_W-1:0] col);
    if (org == ORG_X16) return {bank, row[12:0], col};
    if (org == ORG_X32R) return {1'b0, bank, row, col[7:0]};
    return {1'b0, bank, row[12:0], col[8:0]};
  endfunction

  // ****************************************
  // state
  // ****************************************
  sbc_burst_t       bst, next_bst;
  sbc_pwr_t         pwr, next_pwr;
  logic [BANKS-1:0] open, next_open;
  logic [ROW_W-1:0] rows [BANKS];
  logic [ROW_W-1:0] next_rows [BANKS];
  logic [MR_W-1:0]  mode, next_mode;
  logic [15:0]      rcnt, next_rcnt;
  logic             cke_q;
  logic             v1, v2, v3, next_v1;
  logic [3:0]       m1, m2;
  logic [DQ_W-1:0]  d2, d3;
  logic [1:0]       org, next_org;
  logic [31:0]      next_prdata;

  sbc_cmd_t         cmd;
  logic             en, take, is_act, is_rd, is_wr, is_pre, is_bst, is_ref, is_lmr;
  logic             start_rw, cont, beat, beat_wr, all_idle;
  logic [1:0]       bank_in, beat_bank, blc;
  logic [COL_W-1:0] beat_col;
  logic [ROW_W-1:0] row_in;
  logic [3:0]       lane_mask, lane_on;
  logic [DQ_W-1:0]  rdata;
  logic [31:0]      rd_mux;
  logic             hit, cl3;

  // ****************************************
  // command decode
  // ****************************************
  // clock enable acts one edge late, like a gated internal clock
  // frozen clock
  assign en        = cke_q;
  assign cmd       = '{cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n};
  assign take      = en && (pwr == PW_RUN) && !cmd.cs_n && cke;
  assign is_act    = take && (cmd == CMD_ACT);
  assign is_rd     = take && (cmd == CMD_RD);
  assign is_wr     = take && (cmd == CMD_WR);
  assign is_pre    = take && (cmd == CMD_PRE);
  assign is_bst    = take && (cmd == CMD_BST);
  assign is_ref    = take && (cmd == CMD_REF);
  assign is_lmr    = take && (cmd == CMD_LMR);
  assign bank_in   = {bank_sel_bit1, bank_sel_bit0};
  assign row_in    = (org == ORG_X32R) ? addr : {1'b0, addr[12:0]};
  assign lane_mask = {upper_lane_mask, high_byte_mask, low_byte_mask};
  assign lane_on   = (org == ORG_X16) ? LANES_X16 : LANES_X32;
  assign blc       = mode[MR_BL_LSB +: 2];
  assign cl3       = (mode[MR_CL_LSB +: 3] == CL_THREE);
  assign all_idle  = (open == '0) && (bst.cnt == '0);

  // ****************************************
  // beat selection
  // ****************************************
  // a new column command wins over the running burst
  // column every cycle
  assign start_rw  = (is_rd || is_wr) && open[bank_in];
  assign cont      = en && (bst.cnt != '0) && !start_rw && !is_bst;
  assign beat      = start_rw || cont;
  assign beat_wr   = start_rw ? is_wr : bst.wr;
  assign beat_bank = start_rw ? bank_in : bst.bank;
  assign beat_col  = start_rw ? addr[COL_W-1:0]
                              : burst_col(bst.col, bst.idx, blc, mode[MR_BT_BIT]);

  // ****************************************
  // array
  // ****************************************
  // masked write lanes dropped
  sbc_mem #(
    .AW (MEM_AW),
    .DW (DQ_W)
  ) u_mem (
    .core_clk (core_clk),
    .addr     (MEM_AW'(lin_addr(org, beat_bank, rows[beat_bank], beat_col))),
    .we       (beat && beat_wr),
    .re       (beat && !beat_wr),
    .be       (~lane_mask & lane_on),
    .wdata    (dq_in),
    .rdata    (rdata)
  );

  // ****************************************
  // bank, burst, mode and power next state
  // ****************************************
  always_comb begin
    next_bst  = bst;
    next_open = open;
    next_rows = rows;
    next_mode = mode;
    next_rcnt = rcnt;
    next_pwr  = pwr;
    next_v1   = beat && !beat_wr;
    if (start_rw) begin
      next_bst.wr   = is_wr;
      next_bst.ap   = addr[AP_BIT];
      next_bst.bank = bank_in;
      next_bst.col  = addr[COL_W-1:0];
      next_bst.idx  = 3'h1;
      next_bst.cnt  = 4'((4'h1 << blc) - 4'h1);
      if (blc == 2'h0 && addr[AP_BIT]) begin
        next_open[bank_in] = 1'b0;
      end
    end else if (cont) begin
      next_bst.idx = 3'(bst.idx + 3'h1);
      next_bst.cnt = 4'(bst.cnt - 4'h1);
      if (bst.cnt == 4'h1 && bst.ap) begin
        next_open[bst.bank] = 1'b0;
      end
    end
    if (is_bst) begin
      next_bst.cnt = '0;
    end
    if (is_act) begin
      next_open[bank_in] = 1'b1;
      next_rows[bank_in] = row_in;
    end
    if (is_pre) begin
      if (addr[AP_BIT]) begin
        next_open = '0;
      end else begin
        next_open[bank_in] = 1'b0;
      end
    end
    if (is_ref && all_idle) begin
      next_rcnt = 16'(rcnt + 16'h1);
    end
    if (is_lmr && all_idle) begin
      next_mode = addr[MR_W-1:0];
    end
    unique case (pwr)
      PW_RUN: begin
        if (en && !cke) begin
          if (!cmd.cs_n && cmd == CMD_REF && all_idle) begin
            next_pwr = PW_SELF;
          end else if (!cmd.cs_n && cmd == CMD_BST && all_idle) begin
            next_pwr = PW_DEEP;
          end else if (bst.cnt == '0) begin
            next_pwr = PW_DOWN;
          end
        end
      end
      PW_DOWN, PW_SELF, PW_DEEP: begin
        if (cke) begin
          next_pwr = PW_RUN;
        end
      end
      default: next_pwr = PW_RUN;
    endcase
  end

  // register core state
  // rising edge capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bst   <= '0;
      pwr   <= PW_RUN;
      open  <= '0;
      rows  <= '{default: '0};
      mode  <= MR_RST;
      rcnt  <= '0;
      cke_q <= 1'b0;
      v1    <= 1'b0;
      v2    <= 1'b0;
      v3    <= 1'b0;
      m1    <= '0;
      m2    <= '0;
      d2    <= '0;
      d3    <= '0;
    end else begin
      bst   <= next_bst;
      pwr   <= next_pwr;
      open  <= next_open;
      rows  <= next_rows;
      mode  <= next_mode;
      rcnt  <= next_rcnt;
      cke_q <= cke;
      // read pipe holds while the clock is suspended
      if (en) begin
        v1 <= next_v1;
        v2 <= v1;
        v3 <= v2;
        m1 <= lane_mask;
        m2 <= m1;
        d2 <= rdata;
        d3 <= d2;
      end
    end
  end

  // ****************************************
  // read data drive
  // ****************************************
  // mask floats lanes two clocks on
  assign dq_out = cl3 ? d3 : d2;
  assign dq_oe  = ((cl3 ? v3 : v2) ? ~m2 : 4'h0) & lane_on;

  // ****************************************
  // apb slave
  // ****************************************
  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      REG_CFG:  rd_mux = {30'h0, org};
      REG_STAT: rd_mux = {23'h0, pwr, bst.cnt != '0, open};
      REG_MODE: rd_mux = {25'h0, mode};
      REG_RCNT: rd_mux = {16'h0, rcnt};
      default: begin
        rd_mux = '0;
        hit    = 1'b0;
      end
    endcase
    next_org    = org;
    next_prdata = prdata;
    if (psel && penable && pwrite && paddr == REG_CFG) begin
      next_org = pwdata[1:0];
    end
    if (psel && !penable) begin
      next_prdata = rd_mux;
    end
  end

  // register apb state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      org    <= ORG_RST;
      prdata <= '0;
    end else begin
      org    <= next_org;
      prdata <= next_prdata;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  cs_mask_a: assert property (
    (en && cs_n && bst.cnt == '0 && !is_lmr) |=> (open == $past(open) && mode == $past(mode)))
    else $error("command taken with chip select high");
  act_open_a: assert property (
    (is_act && !is_pre) |=> (open[$past(bank_in)] && rows[$past(bank_in)] == $past(row_in)))
    else $error("activate did not open row");
  pre_all_a: assert property (
    (is_pre && addr[AP_BIT]) |=> (open == '0))
    else $error("precharge all left a bank open");
  pre_one_a: assert property (
    (is_pre && !addr[AP_BIT]) |=> !open[$past(bank_in)])
    else $error("precharge left selected bank open");
  burst_len_a: assert property (
    (start_rw && blc == 2'h2) |=> (bst.cnt == 4'h3 && bst.idx == 3'h1))
    else $error("burst of four loaded wrong count");
  read_lat_a: assert property (
    (beat && !beat_wr && !low_byte_mask && lane_on[0]) ##1 en
      |=> (cl3 || dq_oe[0]))
    else $error("read data not driven after two clocks");
  mask_hiz_a: assert property (
    (en && low_byte_mask) ##1 en |=> !dq_oe[0])
    else $error("masked read lane still driven");
  ap_close_a: assert property (
    (cont && bst.cnt == 4'h1 && bst.ap && !is_act) |=> !open[$past(bst.bank)])
    else $error("auto precharge did not close row");
  suspend_a: assert property (
    (!en && bst.cnt != '0) |=> (bst.cnt == $past(bst.cnt)))
    else $error("burst advanced while clock suspended");
  deep_exit_a: assert property (
    (pwr == PW_DEEP && cke) |=> (pwr == PW_RUN))
    else $error("deep sleep did not exit on clock enable");

endmodule

// ==== sbc_ctrl_model.sv ====
`timescale 1ns/100ps
// ****************************************
// controller model driving the command side
// ****************************************
module sbc_ctrl_model
  import sbc_pkg::*;
(
  input  wire logic         core_clk,        // system clock
  output logic              cke,             // clock enable
  output logic              cs_n,            // chip select
  output logic              ras_n,           // row strobe
  output logic              cas_n,           // column strobe
  output logic              we_n,            // write strobe
  output logic              bank_sel_bit0,   // bank select lsb
  output logic              bank_sel_bit1,   // bank select msb
  output logic [ADDR_W-1:0] addr,            // row/column address
  output logic              low_byte_mask,   // lane 0 mask
  output logic              high_byte_mask,  // lane 1 mask
  output logic [1:0]        upper_lane_mask, // lanes 3:2 mask
  output logic [DQ_W-1:0]   dq_in,           // write data
  output logic [7:0]        bad_cnt          // accesses asked against bank state
);
  logic [BANKS-1:0] bank_open; // rows this controller believes open

  // quiet bus at time zero
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    {bank_sel_bit1, bank_sel_bit0} = 2'h0;
    {upper_lane_mask, high_byte_mask, low_byte_mask} = 4'h0;
    addr = '0;
    dq_in = '0;
    bad_cnt = 8'h0;
    bank_open = '0;
  end

  // one command slot, launched just after an edge
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [ADDR_W-1:0] a, input logic [3:0] m,
                       input logic [DQ_W-1:0] d);
    if ((c == CMD_RD || c == CMD_WR) && !bank_open[b]) bad_cnt++;
    if (c == CMD_ACT && bank_open[b]) bad_cnt++;
    @(posedge core_clk);
    {cs_n, ras_n, cas_n, we_n} <= sbc_cmd_t'(c);
    {bank_sel_bit1, bank_sel_bit0} <= b;
    addr <= a;
    {upper_lane_mask, high_byte_mask, low_byte_mask} <= m;
    dq_in <= d;
    if (c == CMD_ACT) bank_open[b] = 1'b1;
    if ((c == CMD_RD || c == CMD_WR) && a[AP_BIT]) bank_open[b] = 1'b0;
    if (c == CMD_PRE && a[AP_BIT]) bank_open = '0;
    if (c == CMD_PRE && !a[AP_BIT]) bank_open[b] = 1'b0;
  endtask

  // deselect; released lines show the inverse of their last value
  task automatic idle();
    @(posedge core_clk);
    cs_n <= 1'b1;
    addr <= ~addr;
    dq_in <= ~dq_in;
    // masks stay driven by the controller, back to unmasked
    {upper_lane_mask, high_byte_mask, low_byte_mask} <= 4'h0;
  endtask

  // clock enable change with a command on the same edge
  task automatic clk_en(input logic k, input logic [3:0] c);
    @(posedge core_clk);
    cke <= k;
    {cs_n, ras_n, cas_n, we_n} <= sbc_cmd_t'(c);
  endtask
endmodule

// ==== test_sdram_bank_access_core.sv ====
`timescale 1ns/100ps
// ****************************************
// bench for the bank access core
// ****************************************
module test_sdram_bank_access_core;
  import sbc_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_n, psel, penable, pwrite, pready, pslverr, cke, err;
  logic              cs_n, ras_n, cas_n, we_n, bs0, bs1, lbm, hbm;
  logic [1:0]        ulm;
  logic [7:0]        paddr, bad_cnt;
  logic [31:0]       pwdata, prdata, rd;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   dq_in, dq_out;
  logic [LANES-1:0]  dq_oe;
  int                n_errors, samples_checked;
  logic [31:0]       dv[4] = '{32'h0000_1A2B, 32'h0000_3C4D, 32'h0000_5E6F, 32'h0000_7081};

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  sbc_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_sel_bit0(bs0), .bank_sel_bit1(bs1), .addr(addr), .low_byte_mask(lbm),
    .high_byte_mask(hbm), .upper_lane_mask(ulm), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe));

  sbc_ctrl_model i_ctrl (.core_clk(core_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_sel_bit0(bs0), .bank_sel_bit1(bs1), .addr(addr),
    .low_byte_mask(lbm), .high_byte_mask(hbm), .upper_lane_mask(ulm), .dq_in(dq_in),
    .bad_cnt(bad_cnt));

  // ****************************************
  // helpers
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic [31:0] lm(input logic [3:0] e);
    return {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
  endfunction

  // read beats at cas latency two, sampled mid cycle
  task automatic beats(input logic [31:0] ed[$], input logic [3:0] eo[$]);
    repeat (3) @(posedge core_clk);
    foreach (ed[i]) begin
      @(negedge core_clk);
      chk({28'h0, dq_oe}, {28'h0, eo[i]});
      chk(dq_out & lm(eo[i]), ed[i] & lm(eo[i]));
      @(posedge core_clk);
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    n_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(REG_CFG, 32'h0);
    rdchk(REG_MODE, 32'h23);
    rdchk(REG_STAT, 32'h20);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    i_ctrl.issue(CMD_LMR, 2'h0, 14'h0022, 4'h0, '0);
    i_ctrl.idle();
    rdchk(REG_MODE, 32'h22);
    i_ctrl.issue(CMD_ACT, 2'h1, 14'h0ABC, 4'h0, '0);
    i_ctrl.issue(CMD_ACT, 2'h2, 14'h1234, 4'h0, '0);
    i_ctrl.issue(CMD_WR, 2'h1, 14'h0004, 4'h0, dv[0]);
    for (int k = 1; k < 4; k++) begin
      i_ctrl.issue(4'h8, 2'h0, 14'h0000, 4'h0, dv[k]);
    end
    i_ctrl.idle();
    apb(1'b1, REG_STAT, 32'hFF);
    rdchk(REG_STAT, 32'h26);
    // interrupted read, other bank precharged meanwhile
    fork
      begin
        i_ctrl.issue(CMD_RD, 2'h1, 14'h0006, 4'h0, '0);
        i_ctrl.issue(CMD_RD, 2'h1, 14'h0005, 4'h0, '0);
        i_ctrl.issue(CMD_PRE, 2'h2, 14'h0000, 4'h0, '0);
        i_ctrl.idle();
      end
      beats('{dv[2], dv[1], dv[2], dv[3], dv[0]}, '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3});
    join
    rdchk(REG_STAT, 32'h22);
    // read with chip select high gives no data
    fork
      begin
        i_ctrl.issue(4'hD, 2'h1, 14'h0004, 4'h0, '0);
        i_ctrl.idle();
      end
      beats('{32'h0, 32'h0, 32'h0, 32'h0}, '{4'h0, 4'h0, 4'h0, 4'h0});
    join
    // auto precharge read with lane 0 masked on beat 1
    fork
      begin
        i_ctrl.issue(CMD_RD, 2'h1, 14'h0404, 4'h0, '0);
        i_ctrl.issue(4'h8, 2'h0, 14'h0000, 4'h1, '0);
        i_ctrl.idle();
      end
      beats('{dv[0], dv[1], dv[2], dv[3]}, '{4'h3, 4'h2, 4'h3, 4'h3});
    join
    rdchk(REG_STAT, 32'h20);
    i_ctrl.issue(CMD_ACT, 2'h0, 14'h0011, 4'h0, '0);
    i_ctrl.issue(CMD_ACT, 2'h3, 14'h0022, 4'h0, '0);
    i_ctrl.issue(CMD_PRE, 2'h0, 14'h0400, 4'h0, '0);
    i_ctrl.idle();
    rdchk(REG_STAT, 32'h20);
    i_ctrl.issue(CMD_REF, 2'h0, 14'h0000, 4'h0, '0);
    i_ctrl.idle();
    rdchk(REG_RCNT, 32'h1);
    // deep sleep entry and exit, then power down and exit
    i_ctrl.clk_en(1'b0, CMD_BST);
    rdchk(REG_STAT, 32'h100);
    i_ctrl.clk_en(1'b1, 4'h8);
    i_ctrl.clk_en(1'b0, 4'h8);
    rdchk(REG_STAT, 32'h40);
    i_ctrl.clk_en(1'b1, 4'h8);
    rdchk(REG_STAT, 32'h20);
    for (int o = 0; o < 3; o++) begin
      apb(1'b1, REG_CFG, 32'(o));
      rdchk(REG_CFG, 32'(o));
    end
    chk({24'h0, bad_cnt}, 32'h0);
    wrap_up();
  end
endmodule
